// ==== rtl/epp_pkg.sv ====
// shared constants for the eprom program and verify port
// assumes one 20 MHz clock domain and pins synchronised inside the port
package epp_pkg;
   localparam int ADDR_W = 9;
   localparam int INS_W = 23;
   localparam int DAT_W = 13;
   localparam int BYTE_W = 8;
   localparam int SYNC_DEPTH = 2;
   // cycles after reset release before the strap pins are read
   localparam logic [1:0] CAPTURE_WAIT = 2'h3;
   localparam logic [8:0] INS_ADDR_RST = 9'h000;
   localparam logic [8:0] INS_ADDR_END = 9'h1FF;
   localparam logic [8:0] DAT_ADDR_RST = 9'h1FF;
   localparam logic [8:0] DAT_ADDR_END = 9'h000;
   localparam logic [7:0] DATA_OUT_RST = 8'h00;
   // instruction word field positions
   localparam int INS_HI_LSB = 15;
   localparam int INS_MID_LSB = 8;
   localparam int INS_MID_W = 7;
   // data word: high byte holds bits 12..5, low byte bits 4..0 then padding
   localparam int DAT_HI_LSB = 5;
   localparam int DAT_LO_W = 5;
   localparam int DAT_PAD_W = 3;
   // mode straps {dma_ack_n, register_select_line, serial input}
   localparam logic [2:0] STRAP_WRITE = 3'h0;
   localparam logic [2:0] STRAP_IREAD = 3'h1;
   localparam logic [2:0] STRAP_DREAD = 3'h2;
   // byte selects {register_select_line, serial input, interrupt pin}
   localparam logic [2:0] SEL_INS_HI = 3'h1;
   localparam logic [2:0] SEL_INS_MID = 3'h2;
   localparam logic [2:0] SEL_INS_LO = 3'h3;
   localparam logic [2:0] SEL_DAT_LO = 3'h4;
   localparam logic [2:0] SEL_DAT_HI = 3'h5;
   localparam logic [2:0] SEL_DAT_RD = 3'h0;
   typedef enum logic [3:0] {
      EPP_MODE_NONE  = 4'b0001,
      EPP_MODE_WRITE = 4'b0010,
      EPP_MODE_IREAD = 4'b0100,
      EPP_MODE_DREAD = 4'b1000
   } epp_mode_t;
endpackage

// ==== rtl/epp_port.sv ====
// program and verify access path to the instruction and data eproms
// assumes all control pins and the step clock arrive asynchronously
// and the programmer pulses erase_req once before the first program cycle
//
// Functional notes
// - instruction words move as three bytes, data words as two bytes
// - instruction bytes are bit reversed between store and data port
// - data bytes keep natural bit order on the data port
// - eprom bits read zero when erased; programming only sets ones
// - mode straps sampled at reset release with strobes and select low
// - straps 000 write both arrays, 001 read instructions, 010 read data
// - captured mode holds until the next reset
// - write mode byte selects: 001,010,011 instruction; 100,101 data
// - instruction read: strobe low, select low, 01 high 10 mid 11 low
// - data read: strobe high, all selects low, drives the data word
// - instruction counter resets to 000 and counts up to 1FF
// - data counter resets to 1FF and counts down to 000
// - bytes are latched on the falling read strobe in program mode
// - one step clock cycle advances each active counter by one; write mode steps both
// - data read shows low byte after a step, read pulse switches high
`timescale 1ns/1ps
module epp_port #(
   parameter int DEPTH = 512
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic       read_strobe_n,
   input  wire logic       write_strobe_n,
   input  wire logic       chip_select_program_n,
   input  wire logic       dma_ack_n,
   input  wire logic       register_select_line,
   input  wire logic       serial_in,
   input  wire logic       interrupt_in,
   input  wire logic       step_clk_in,
   input  wire logic       erase_req,
   input  wire logic [7:0] data_in,
   output logic [7:0]      data_out,
   output logic            data_oe_n,
   output logic [3:0]      mode,
   output logic [8:0]      instruction_location_counter,
   output logic [8:0]      data_location_counter,
   output logic            load_ready
);
   localparam int NPIN = 16;
   typedef logic [epp_pkg::ADDR_W-1:0] epp_addr_t;

   // two-flop synchroniser over every pin but erase_req; a third stage holds the previous sample for edge detection
   logic [NPIN-1:0] pin_s1_r;
   logic [NPIN-1:0] pin_s2_r;
   logic [NPIN-1:0] pin_s3_r;
   wire  [NPIN-1:0] pin_raw = {data_in, step_clk_in, interrupt_in, serial_in,
                               register_select_line, dma_ack_n,
                               chip_select_program_n, write_strobe_n,
                               read_strobe_n};
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
      end else if (ce) begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   wire       rd_n = pin_s2_r[0];
   wire       wr_n = pin_s2_r[1];
   wire       prog_n = pin_s2_r[2];
   wire       dma_ack_n_n = pin_s2_r[3];
   wire       rsel = pin_s2_r[4];
   wire       sin = pin_s2_r[5];
   wire       intp = pin_s2_r[6];
   wire [7:0] dpin = pin_s2_r[15:8];
   wire       rd_fall = pin_s3_r[0] && !rd_n;
   wire       prog_rise = !pin_s3_r[2] && prog_n;
   wire       step_evt = !pin_s3_r[7] && pin_s2_r[7];
   wire [2:0] strap = {dma_ack_n_n, rsel, sin};
   wire [2:0] bsel = {rsel, sin, intp};

   // mode capture once the synchronisers hold the strap levels
   epp_pkg::epp_mode_t mode_r;
   epp_pkg::epp_mode_t mode_nxt;
   logic [1:0]         cap_cnt_r;
   logic               captured_r;
   wire  straps_ok = !rd_n && !wr_n && !prog_n;
   wire  cap_now = !captured_r && (cap_cnt_r == epp_pkg::CAPTURE_WAIT);
   always_comb begin
      mode_nxt = epp_pkg::EPP_MODE_NONE;
      if (straps_ok) begin
         unique case (strap)
            epp_pkg::STRAP_WRITE: mode_nxt = epp_pkg::EPP_MODE_WRITE;
            epp_pkg::STRAP_IREAD: mode_nxt = epp_pkg::EPP_MODE_IREAD;
            epp_pkg::STRAP_DREAD: mode_nxt = epp_pkg::EPP_MODE_DREAD;
            default:              mode_nxt = epp_pkg::EPP_MODE_NONE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= epp_pkg::EPP_MODE_NONE;
         cap_cnt_r <= 2'h0;
         captured_r <= 1'b0;
      end else if (ce && !captured_r) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
         if (cap_now) begin
            mode_r <= mode_nxt;
            captured_r <= 1'b1;
         end
      end
   end
   wire m_wr = (mode_r == epp_pkg::EPP_MODE_WRITE);
   wire m_ir = (mode_r == epp_pkg::EPP_MODE_IREAD);
   wire m_dr = (mode_r == epp_pkg::EPP_MODE_DREAD);

   // bit reversal shared by load and drive paths
   wire [7:0] dpin_rev;
   logic [7:0] ins_byte;
   wire [7:0] ins_byte_rev;
   for (genvar i = 0; i < 8; i++) begin : g_rev
      assign dpin_rev[i] = dpin[7-i];
      assign ins_byte_rev[i] = ins_byte[7-i];
   end

   // load path through the two-entry buffer; it stalls during the pulse
   wire        sel_ok = (bsel >= epp_pkg::SEL_INS_HI) && (bsel <= epp_pkg::SEL_DAT_HI);
   wire        ld_valid = m_wr && !rd_n && rd_fall && sel_ok;
   wire        buf_in_ready;
   wire        buf_valid;
   wire [10:0] buf_data;
   wire        drain = !prog_n && !step_evt;
   // strobe level at the fall is low; the select is taken from the same sample
   wire [10:0] push_word = {bsel, (bsel[2] ? dpin : dpin_rev)};
   epp_skid #(.W(11)) u_skid (
      .clk       (clk),
      .resetn    (resetn),
      .ce        (ce),
      .in_valid  (ld_valid),
      .in_ready  (buf_in_ready),
      .in_data   (push_word),
      .out_valid (buf_valid),
      .out_ready (drain),
      .out_data  (buf_data)
   );

   // staging latch, cleared on a step so the next location starts clean
   logic [7:0] st_ins_hi_r;
   logic [6:0] st_ins_mid_r;
   logic [7:0] st_ins_lo_r;
   logic [7:0] st_dat_hi_r;
   logic [4:0] st_dat_lo_r;
   wire        take = buf_valid && drain;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ins_hi_r <= '0;
         st_ins_mid_r <= '0;
         st_ins_lo_r <= '0;
         st_dat_hi_r <= '0;
         st_dat_lo_r <= '0;
      end else if (ce) begin
         if (step_evt) begin
            st_ins_hi_r <= '0;
            st_ins_mid_r <= '0;
            st_ins_lo_r <= '0;
            st_dat_hi_r <= '0;
            st_dat_lo_r <= '0;
         end else if (take) begin
            unique case (buf_data[10:8])
               epp_pkg::SEL_INS_HI:  st_ins_hi_r <= buf_data[7:0];
               // stored bit 7 of the middle byte has no cell behind it
               epp_pkg::SEL_INS_MID: st_ins_mid_r <= buf_data[6:0];
               epp_pkg::SEL_INS_LO:  st_ins_lo_r <= buf_data[7:0];
               epp_pkg::SEL_DAT_LO:  st_dat_lo_r <= buf_data[7:3];
               epp_pkg::SEL_DAT_HI:  st_dat_hi_r <= buf_data[7:0];
               default:              st_ins_hi_r <= st_ins_hi_r;
            endcase
         end
      end
   end
   wire [22:0] ins_stage = {st_ins_hi_r, st_ins_mid_r, st_ins_lo_r};
   wire [12:0] dat_stage = {st_dat_hi_r, st_dat_lo_r};

   // location counters stop at their final address
   epp_addr_t ins_addr_r;
   epp_addr_t dat_addr_r;
   wire ins_step = step_evt && (m_wr || m_ir) && (ins_addr_r != epp_pkg::INS_ADDR_END);
   wire dat_step = step_evt && (m_wr || m_dr) && (dat_addr_r != epp_pkg::DAT_ADDR_END);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ins_addr_r <= epp_pkg::INS_ADDR_RST;
         dat_addr_r <= epp_pkg::DAT_ADDR_RST;
      end else if (ce) begin
         if (ins_step) ins_addr_r <= ins_addr_r + 9'h001;
         if (dat_step) dat_addr_r <= dat_addr_r - 9'h001;
      end
   end

   // eprom cells: a cleared valid flag reads as the erased all-zero word
   logic [22:0]      ins_mem [DEPTH];
   logic [12:0]      dat_mem [DEPTH];
   logic [DEPTH-1:0] ins_vld_r;
   logic [DEPTH-1:0] dat_vld_r;
   wire  [22:0] ins_word = ins_vld_r[ins_addr_r] ? ins_mem[ins_addr_r] : '0;
   wire  [12:0] dat_word = dat_vld_r[dat_addr_r] ? dat_mem[dat_addr_r] : '0;
   wire         do_prog = ce && m_wr && prog_rise;
   always_ff @(posedge clk) begin
      if (ce && erase_req) begin
         ins_vld_r <= '0;
         dat_vld_r <= '0;
      end else if (do_prog) begin
         ins_mem[ins_addr_r] <= ins_word | ins_stage;
         dat_mem[dat_addr_r] <= dat_word | dat_stage;
         ins_vld_r[ins_addr_r] <= 1'b1;
         dat_vld_r[dat_addr_r] <= 1'b1;
      end
   end

   // read drive selection
   logic dhi_r;
   always_comb begin
      unique case (bsel[1:0])
         2'h1:    ins_byte = ins_word[22:15];
         2'h2:    ins_byte = {1'b0, ins_word[14:8]};
         default: ins_byte = ins_word[7:0];
      endcase
   end
   wire ir_drive = m_ir && !rd_n && !rsel && (bsel[1:0] != 2'h0);
   wire dr_drive = m_dr && rd_n && (bsel == epp_pkg::SEL_DAT_RD);
   wire [7:0] dat_byte = dhi_r ? dat_word[12:5] : {dat_word[4:0], 3'h0};
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dhi_r <= 1'b0;
         data_out <= epp_pkg::DATA_OUT_RST;
         data_oe_n <= 1'b1;
         load_ready <= 1'b1;
      end else if (ce) begin
         if (step_evt) dhi_r <= 1'b0;
         else if (m_dr && rd_fall) dhi_r <= 1'b1;
         data_out <= ir_drive ? ins_byte_rev : dat_byte;
         data_oe_n <= !(ir_drive || dr_drive);
         load_ready <= buf_in_ready;
      end
   end
   assign mode = mode_r;
   assign instruction_location_counter = ins_addr_r;
   assign data_location_counter = dat_addr_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_mode_hold: assert property (captured_r |=> mode_r == $past(mode_r))
      else $error("mode changed after capture");
   chk_mode_write: assert property (ce && cap_now && straps_ok
      && strap == epp_pkg::STRAP_WRITE |=> m_wr) else $error("write strap missed");
   chk_ins_count: assert property (ce && ins_step |=>
      ins_addr_r == $past(ins_addr_r) + 9'h001) else $error("instruction step wrong");
   chk_dat_count: assert property (ce && dat_step |=>
      dat_addr_r == $past(dat_addr_r) - 9'h001) else $error("data step wrong");
   chk_stage_clear: assert property (ce && step_evt |=>
      ins_stage == '0 && dat_stage == '0) else $error("staging not cleared");
   chk_ins_reverse: assert property (ce && ir_drive |=>
      data_out == $past(ins_byte_rev) && !data_oe_n) else $error("instruction byte order");
   chk_dat_natural: assert property (ce && dr_drive && !dhi_r && !step_evt
      && !rd_fall |=> data_out == {$past(dat_word[4:0]), 3'h0}) else $error("data low byte");
   chk_write_quiet: assert property (m_wr |-> data_oe_n)
      else $error("port driven in write mode");
   chk_idle_count: assert property (mode_r == epp_pkg::EPP_MODE_NONE
      |-> ins_addr_r == epp_pkg::INS_ADDR_RST) else $error("counter moved without mode");
   cov_write: cover property (do_prog);
   cov_ins_read: cover property (ce && ir_drive);
   cov_dat_high: cover property (ce && dr_drive && dhi_r);
   cov_buf_full: cover property (!buf_in_ready);
endmodule

// ==== rtl/epp_skid.sv ====
// two-entry buffer with valid and ready on both sides
// assumes the caller holds out_ready low to stall; ce freezes all state
`timescale 1ns/1ps
module epp_skid #(
   parameter int W = 11
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] slot_r [2];
   logic         wptr_r;
   logic         rptr_r;
   logic [1:0]   cnt_r;
   wire          push = in_valid && in_ready;
   wire          pop = out_valid && out_ready;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = slot_r[rptr_r];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else if (ce) begin
         if (push) wptr_r <= ~wptr_r;
         if (pop) rptr_r <= ~rptr_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) slot_r[wptr_r] <= in_data;
   end

   chk_skid_full: assert property (@(posedge clk) disable iff (!resetn)
      cnt_r <= 2'h2) else $error("skid count out of range");
endmodule

// ==== tb/epp_prog_model.sv ====
// programmer model: drives the control pins and the data lane of the port
// assumes pins are changed at the falling clock edge and held for 8 cycles
`timescale 1ns/1ps
module epp_prog_model (
   input  wire logic clk,
   output logic      rd_n,
   output logic      wr_n,
   output logic      cs_n,
   output logic      dma_ack_n_n,
   output logic      rsel,
   output logic      si,
   output logic      intr,
   output logic      step,
   output logic      erase,
   output logic [7:0] dout
);
   initial begin
      {rd_n, wr_n, cs_n, dma_ack_n_n, rsel, si, intr, step, erase} = '0;
      dout = 8'h00;
   end
   function automatic logic [7:0] flip(input logic [7:0] b);
      for (int i = 0; i < 8; i++) flip[i] = b[7 - i];
   endfunction
   // the port synchronises every pin but erase_req, so each level stands well past 4 cycles
   task automatic hold();
      repeat (8) @(negedge clk);
   endtask
   task automatic straps(input logic [2:0] s);
      @(negedge clk);
      {rd_n, wr_n, cs_n, intr} = '0;
      {dma_ack_n_n, rsel, si} = s;
   endtask
   task automatic read_sel(input logic rd, input logic [2:0] s);
      @(negedge clk);
      rd_n = rd;
      {rsel, si, intr} = s;
      hold();
   endtask
   task automatic run_mode();
      @(negedge clk);
      wr_n = 1'b1;
      read_sel(1'b1, 3'h0);
   endtask
   // the lane shows the inverse between loads, so a late sample is caught
   task automatic load(input logic [2:0] s, input logic [7:0] b);
      @(negedge clk);
      dout = b;
      rd_n = 1'b1;
      {rsel, si, intr} = s;
      hold();
      read_sel(1'b0, s);
      read_sel(1'b1, s);
      @(negedge clk);
      dout = ~b;
   endtask
   task automatic load_ins(input logic [22:0] w, input int k);
      if (k == 0) load(epp_pkg::SEL_INS_HI, flip(w[22:15]));
      if (k == 1) load(epp_pkg::SEL_INS_MID, flip({1'b0, w[14:8]}));
      if (k == 2) load(epp_pkg::SEL_INS_LO, flip(w[7:0]));
   endtask
   task automatic load_dat(input logic [12:0] w);
      load(epp_pkg::SEL_DAT_LO, {w[4:0], 3'h0});
      load(epp_pkg::SEL_DAT_HI, w[12:5]);
   endtask
   task automatic set_prog(input logic v);
      @(negedge clk);
      cs_n = v;
      hold();
   endtask
   task automatic pulse_step();
      @(negedge clk);
      step = 1'b1;
      hold();
      step = 1'b0;
      hold();
   endtask
   // erase once so cells start at zero before the first program pulse
   task automatic erase_all();
      @(negedge clk);
      erase = 1'b1;
      hold();
      erase = 1'b0;
   endtask
endmodule

// ==== tb/test_epp_port.sv ====
// self-checking bench: write a location, then read it back in both read modes
// assumes the port's mode survives only until reset and cells persist over reset
`timescale 1ns/1ps
module test_epp_port;
   localparam logic [22:0] INS = {8'hA3, 7'h35, 8'h1E};
   localparam logic [12:0] DAT = 13'h16B5;
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic       ce = 1'b1;
   logic       rd_n, wr_n, cs_n, dma_ack_n_n, rsel, si, intr, step, erase;
   logic [7:0] din, data_out;
   logic       data_oe_n, load_ready;
   logic [3:0] mode;
   logic [8:0] ins_cnt, dat_cnt;
   int         mismatches = 0;
   int         num_checks = 0;
   int         cycles = 0;
   always #25 clk = ~clk;
   epp_prog_model prog (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .dma_ack_n_n(dma_ack_n_n),
      .rsel(rsel), .si(si), .intr(intr), .step(step), .erase(erase), .dout(din));
   epp_port dut (.clk(clk), .resetn(resetn), .ce(ce), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .chip_select_program_n(cs_n), .dma_ack_n(dma_ack_n_n),
      .register_select_line(rsel), .serial_in(si), .interrupt_in(intr),
      .step_clk_in(step), .erase_req(erase), .data_in(din), .data_out(data_out),
      .data_oe_n(data_oe_n), .mode(mode), .instruction_location_counter(ins_cnt),
      .data_location_counter(dat_cnt), .load_ready(load_ready));
   function automatic logic [7:0] rev8(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
   endfunction
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({8'h00, got}, {8'h00, exp});
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      chk({1'b0, got}, {1'b0, exp});
   endtask
   task automatic chk_mode(input epp_pkg::epp_mode_t m);
      chk({5'h00, mode}, {5'h00, m});
   endtask
   // reset stands two cycles; straps go up inside it and hold well past release
   task automatic do_reset(input logic [2:0] s);
      resetn = 1'b0;
      prog.straps(s);
      @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      prog.run_mode();
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic test_write();
      do_reset(epp_pkg::STRAP_WRITE);
      chk_mode(epp_pkg::EPP_MODE_WRITE);
      chk(ins_cnt, epp_pkg::INS_ADDR_RST);
      chk(dat_cnt, epp_pkg::DAT_ADDR_RST);
      prog.erase_all();
      // program pin high stops the drain, so two loads fill the buffer
      prog.set_prog(1'b1);
      prog.load_ins(INS, 0);
      prog.load_ins(INS, 1);
      chk_bit(load_ready, 1'b0);
      prog.set_prog(1'b0);
      chk_bit(load_ready, 1'b1);
      prog.load_ins(INS, 2);
      prog.load_dat(DAT);
      prog.set_prog(1'b1);
      prog.set_prog(1'b0);
      prog.pulse_step();
      chk(ins_cnt, 9'h001);
      chk(dat_cnt, 9'h1FE);
      $display("test write done");
   endtask
   task automatic test_iread();
      do_reset(epp_pkg::STRAP_IREAD);
      chk_mode(epp_pkg::EPP_MODE_IREAD);
      prog.read_sel(1'b0, 3'h1);
      chk_byte(data_out, rev8(INS[22:15]));
      chk_bit(data_oe_n, 1'b0);
      prog.read_sel(1'b0, 3'h2);
      chk_byte(data_out, rev8({1'b0, INS[14:8]}));
      prog.read_sel(1'b0, 3'h3);
      chk_byte(data_out, rev8(INS[7:0]));
      prog.read_sel(1'b1, 3'h4);
      chk_mode(epp_pkg::EPP_MODE_IREAD);
      prog.pulse_step();
      chk(ins_cnt, 9'h001);
      chk(dat_cnt, epp_pkg::DAT_ADDR_RST);
      prog.read_sel(1'b0, 3'h1);
      chk_byte(data_out, 8'h00);
      $display("test instruction read done");
   endtask
   task automatic test_dread();
      do_reset(3'h7);
      chk_mode(epp_pkg::EPP_MODE_NONE);
      do_reset(epp_pkg::STRAP_DREAD);
      chk_mode(epp_pkg::EPP_MODE_DREAD);
      chk_byte(data_out, {DAT[4:0], 3'h0});
      chk_bit(data_oe_n, 1'b0);
      prog.read_sel(1'b0, 3'h0);
      prog.read_sel(1'b1, 3'h0);
      chk_byte(data_out, DAT[12:5]);
      // a step pulse that arrives while the clock enable is low must be lost
      ce = 1'b0;
      prog.pulse_step();
      chk(dat_cnt, epp_pkg::DAT_ADDR_RST);
      ce = 1'b1;
      prog.pulse_step();
      chk(dat_cnt, 9'h1FE);
      chk(ins_cnt, epp_pkg::INS_ADDR_RST);
      chk_byte(data_out, 8'h00);
      $display("test data read done");
   endtask
   // the three tests need well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      test_write();
      test_iread();
      test_dread();
      close_out();
   end
endmodule
